// ### design/tpsq_pkg.sv
// package with the constants and types of the two-axis position sequencer
`default_nettype none
package tpsq_pkg;
  localparam int TPSQ_POS_W = 16;
  typedef logic signed [TPSQ_POS_W-1:0] tpsq_pos_t;
  typedef logic [TPSQ_POS_W-1:0] tpsq_vel_t;
  // register byte addresses, axis block at 0x00 and 0x40
  localparam logic [7:0] TPSQ_AXIS_STRIDE = 8'h40;
  localparam logic [5:0] TPSQ_OFS_CTRL = 6'h00;
  localparam logic [5:0] TPSQ_OFS_CMD_POS = 6'h04;
  localparam logic [5:0] TPSQ_OFS_VEL_LIM = 6'h08;
  localparam logic [5:0] TPSQ_OFS_DECEL_A = 6'h0C;
  localparam logic [5:0] TPSQ_OFS_DECEL_B = 6'h10;
  localparam logic [5:0] TPSQ_OFS_STOP_DIST = 6'h14;
  localparam logic [5:0] TPSQ_OFS_JOG_VEL = 6'h18;
  localparam logic [5:0] TPSQ_OFS_WINDOW = 6'h1C;
  localparam logic [5:0] TPSQ_OFS_ACCEL = 6'h20;
  localparam logic [5:0] TPSQ_OFS_ACT_POS = 6'h24;
  localparam logic [5:0] TPSQ_OFS_STATUS = 6'h28;
  localparam logic [7:0] TPSQ_ADDR_MODE = 8'h80;
  localparam logic [7:0] TPSQ_ADDR_IRQ_STAT = 8'h84;
  localparam logic [7:0] TPSQ_ADDR_IRQ_MASK = 8'h88;
  // control register fields
  localparam int TPSQ_CTRL_ENABLE = 0;
  localparam int TPSQ_CTRL_START = 1;
  localparam int TPSQ_CTRL_JOG_PLUS = 2;
  localparam int TPSQ_CTRL_JOG_MINUS = 3;
  // mode register fields
  localparam int TPSQ_MODE_SYNC = 0;
  localparam int TPSQ_MODE_AVG = 1;
  localparam int TPSQ_MODE_ROOT = 2;
  localparam int TPSQ_MODE_NC = 3;
  localparam logic [3:0] TPSQ_MODE_RESET = 4'h4;
  // status register fields
  localparam int TPSQ_STAT_READY = 0;
  localparam int TPSQ_STAT_REACHED = 1;
  localparam int TPSQ_STAT_WINDOW = 2;
  localparam int TPSQ_STAT_MOVING = 3;
  // interrupt bits: reached per axis in [1:0], window entry per axis in [3:2]
  localparam int TPSQ_IRQ_W = 4;
  // reset values of the per-axis settings
  localparam tpsq_vel_t TPSQ_VEL_LIM_RESET = 16'h1000;
  localparam tpsq_vel_t TPSQ_DECEL_RESET = 16'h0400;
  localparam tpsq_vel_t TPSQ_STOP_RESET = 16'h0100;
  localparam tpsq_vel_t TPSQ_JOG_VEL_RESET = 16'h0200;
  localparam tpsq_vel_t TPSQ_WINDOW_RESET = 16'h0040;
  localparam tpsq_vel_t TPSQ_ACCEL_RESET = 16'h0010;
  // reached tolerance in position counts, ratio scale and sync gain shift
  localparam logic [TPSQ_POS_W:0] TPSQ_REACH_TOL = 17'h00002;
  localparam int TPSQ_RATIO_SH = 8;
  localparam int TPSQ_SYNC_SH = 2;
endpackage
`default_nettype wire

// ### design/tpsq_axis_if.sv
// interface carrying settings and state between the top and one axis
`default_nettype none
interface tpsq_axis_if;
  import tpsq_pkg::*;
  logic enable;
  logic start;
  logic jog_plus;
  logic jog_minus;
  tpsq_pos_t cmd_pos;
  tpsq_pos_t act_pos;
  tpsq_vel_t vel_lim;
  tpsq_vel_t decel_a;
  tpsq_vel_t decel_b;
  tpsq_vel_t stop_dist;
  tpsq_vel_t jog_vel;
  tpsq_vel_t window;
  tpsq_vel_t accel;
  logic root_decel_curve;
  logic nc_mode;
  logic sync_ovr;
  tpsq_pos_t sync_vel;
  tpsq_pos_t sync_corr;
  tpsq_pos_t drive;
  tpsq_pos_t target;
  logic target_reached_flag;
  logic in_window;
  modport ctl(output enable, start, jog_plus, jog_minus, cmd_pos, act_pos, vel_lim, decel_a, decel_b,
    stop_dist, jog_vel, window, accel, root_decel_curve, nc_mode, sync_ovr, sync_vel, sync_corr,
    input drive, target, target_reached_flag, in_window);
  modport axis(input enable, start, jog_plus, jog_minus, cmd_pos, act_pos, vel_lim, decel_a, decel_b,
    stop_dist, jog_vel, window, accel, root_decel_curve, nc_mode, sync_ovr, sync_vel, sync_corr,
    output drive, target, target_reached_flag, in_window);
endinterface
`default_nettype wire

// ### design/tpsq_axis.sv
// one positioning axis: target handling, deceleration profile, jog and flags
`default_nettype none
module tpsq_axis
  import tpsq_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  tpsq_axis_if.axis ax
);
  localparam int W = TPSQ_POS_W;
  logic en_q, start_q, jog_q;
  logic [W-1:0] nc_q, nc_d;
  tpsq_pos_t target_q, target_d, drive_q, drive_d;
  logic reached_q, reached_d, win_q, win_d;

  wire en_rise = ax.enable & ~en_q;
  wire start_rise = ax.enable & ax.start & ~start_q;
  wire start_fall = ax.enable & ~ax.start & start_q;
  // both jog bits at once cancel rather than pick a direction
  wire jog = ax.enable & ~ax.start & (ax.jog_plus ^ ax.jog_minus);
  wire jog_rel = ax.enable & ~ax.start & jog_q & ~jog;
  wire signed [W:0] err = $signed({target_q[W-1], target_q}) - $signed({ax.act_pos[W-1], ax.act_pos});
  wire dir_pos = ~err[W];
  wire [W:0] mag = dir_pos ? err : -err;
  wire signed [W:0] cmd_err = $signed({ax.cmd_pos[W-1], ax.cmd_pos}) - $signed({ax.act_pos[W-1], ax.act_pos});
  wire [W:0] cmd_mag = cmd_err[W] ? -cmd_err : cmd_err;
  wire near_cmd = cmd_mag <= TPSQ_REACH_TOL;
  wire near_tgt = mag <= TPSQ_REACH_TOL;
  wire [W-1:0] decel_sel = dir_pos ? ax.decel_a : ax.decel_b;
  // ratio of remaining stroke to deceleration distance, 256 = full speed
  wire full_speed = (decel_sel == '0) || (mag >= {1'b0, decel_sel});
  wire [W+TPSQ_RATIO_SH:0] ratio_div = {mag, TPSQ_RATIO_SH'(0)} / {9'h000, decel_sel};
  wire [9:0] ratio = full_speed ? 10'h100 : 10'(ratio_div);
  // root-like curve r(2-r): steep near target, shorter stops for normal valves
  wire [19:0] ratio_sq = ratio * ratio;
  wire [9:0] root_ratio = 10'({ratio, 1'b0} - 11'(ratio_sq >> TPSQ_RATIO_SH));
  wire [9:0] shape = ax.root_decel_curve ? root_ratio : ratio;
  wire [W+9:0] prof_prod = ax.vel_lim * shape;
  wire [W-1:0] prof_mag = W'(prof_prod >> TPSQ_RATIO_SH);
  // nc profile: speed climbs by accel per cycle, stroke curve caps it on approach
  wire [W:0] nc_up = {1'b0, nc_q} + {1'b0, ax.accel};
  assign nc_d = (!ax.enable || near_tgt) ? '0 : (nc_up > {1'b0, prof_mag}) ? prof_mag : W'(nc_up);
  wire [W-1:0] raw_mag = jog ? ax.jog_vel : ax.nc_mode ? nc_q : prof_mag;
  wire [W-1:0] lim_mag = (raw_mag > ax.vel_lim) ? ax.vel_lim : raw_mag;
  wire [W-2:0] pos_max = '1;
  wire [W-1:0] sat_mag = lim_mag[W-1] ? {1'b0, pos_max} : lim_mag;
  wire jog_dir = ax.jog_plus;
  wire base_pos = jog ? jog_dir : dir_pos;
  wire signed [W+1:0] base_vel = (!jog && near_tgt) ? '0 :
    base_pos ? $signed({2'b00, sat_mag}) : -$signed({2'b00, sat_mag});
  wire signed [W+1:0] corr_vel = base_vel + $signed({{2{ax.sync_corr[W-1]}}, ax.sync_corr});
  wire signed [W+1:0] vmax = $signed({3'b000, pos_max});
  wire signed [W-1:0] sum_sat = (corr_vel > vmax) ? W'(vmax) : (corr_vel < -vmax) ? W'(-vmax) : W'(corr_vel);
  // the synchronizing loop replaces the own loop of a slave axis
  assign drive_d = !ax.enable ? '0 : ax.sync_ovr ? ax.sync_vel : sum_sat;
  // stop point ahead in the direction of travel, or stay if nearer than that
  wire signed [W+1:0] stop_pt = $signed({{2{ax.act_pos[W-1]}}, ax.act_pos}) +
    (drive_q[W-1] ? -$signed({2'b00, ax.stop_dist}) : $signed({2'b00, ax.stop_dist}));
  wire stop_keep = mag <= {1'b0, ax.stop_dist};

  always_comb begin
    target_d = target_q;
    if (en_rise) begin
      target_d = ax.act_pos;
    end else if (start_rise) begin
      target_d = ax.cmd_pos;
    end else if (start_fall && drive_q != '0 && !stop_keep) begin
      target_d = W'(stop_pt);
    end else if (jog || jog_rel) begin
      target_d = ax.act_pos;
    end
  end

  assign reached_d = start_rise ? near_cmd : (ax.enable && !jog && !en_rise && near_tgt);
  assign win_d = ax.enable && ax.start && !start_rise && (mag <= {1'b0, ax.window});

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_q <= 1'b0;
      start_q <= 1'b0;
      jog_q <= 1'b0;
      nc_q <= '0;
      target_q <= '0;
      drive_q <= '0;
      reached_q <= 1'b0;
      win_q <= 1'b0;
    end else begin
      en_q <= ax.enable;
      start_q <= ax.enable & ax.start;
      jog_q <= jog;
      nc_q <= nc_d;
      target_q <= target_d;
      drive_q <= drive_d;
      reached_q <= reached_d;
      win_q <= win_d;
    end
  end

  assign ax.drive = drive_q;
  assign ax.target = target_q;
  assign ax.target_reached_flag = reached_q;
  assign ax.in_window = win_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_jog_held;
    jog ##1 jog;
  endsequence
  sequence s_jog_drop;
    s_jog_held ##1 jog_rel;
  endsequence
  a_enable_loads_target: assert property (en_rise |=> target_q == $past(ax.act_pos))
    else $error("enable did not load the sensor position");
  // enable and start in one write: the sensor position is taken and the command value is never taken
  a_start_takes_cmd: assert property (start_rise && !en_rise |=> target_q == $past(ax.cmd_pos))
    else $error("start did not take the command value");
  a_disabled_idle: assert property (!ax.enable |=> drive_q == '0 && !reached_q && !win_q)
    else $error("disabled axis not idle");
  a_new_target_clear: assert property (start_rise && !near_cmd |=> !reached_q)
    else $error("reached flag kept after new far target");
  a_window_needs_start: assert property (win_q |-> $past(ax.start) && $past(ax.enable))
    else $error("window flag without start");
  a_speed_limited: assert property (ax.enable && !ax.sync_ovr && ax.sync_corr == '0 |=>
    (drive_q[W-1] ? -drive_q : drive_q) <= $past(ax.vel_lim))
    else $error("drive above velocity limit");
  a_jog_release_hold: assert property (s_jog_drop |=> target_q == $past(ax.act_pos))
    else $error("jog release did not hold actual position");
  a_reached_at_target: assert property (ax.enable && !jog && !start_rise && !en_rise && near_tgt |=>
    reached_q)
    else $error("reached flag missing at target");
endmodule
`default_nettype wire

// ### design/tpsq_top.sv
// two-axis position sequencer: register port, sensor inputs, sync controller, interrupt
`default_nettype none
module tpsq_top
  import tpsq_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [TPSQ_POS_W-1:0] sensor_pos_a,
  input wire logic [TPSQ_POS_W-1:0] sensor_pos_b,
  output logic [TPSQ_POS_W-1:0] valve_cmd_a,
  output logic [TPSQ_POS_W-1:0] valve_cmd_b,
  output logic ready,
  output logic [1:0] target_reached_flag,
  output logic [1:0] in_window,
  output logic irq
);
  localparam int W = TPSQ_POS_W;
  tpsq_axis_if ax [2] ();

  logic [W-1:0] pin_s1 [2];
  logic [W-1:0] pin_s2 [2];
  logic [3:0] ctrl_q [2];
  tpsq_pos_t cmd_q [2];
  tpsq_vel_t vlim_q [2], deca_q [2], decb_q [2], stop_q [2], jogv_q [2], win_q [2], acc_q [2];
  logic [3:0] mode_q;
  logic [TPSQ_IRQ_W-1:0] ists_q, imask_q, ev_prev_q;
  logic ready_q;
  logic [31:0] rdata_q;
  tpsq_pos_t drv [2];
  logic [1:0] reached, inwin;

  wire [1:0] axis_hit;
  wire [5:0] axis_ofs = addr[5:0];
  wire wr_mode = wr && addr == TPSQ_ADDR_MODE;
  wire wr_istat = wr && addr == TPSQ_ADDR_IRQ_STAT;
  wire wr_imask = wr && addr == TPSQ_ADDR_IRQ_MASK;

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_axis
      assign axis_hit[i] = addr[7:6] == 2'(i);
      wire w = wr && axis_hit[i];
      // sensor bits arrive from outside the clock domain
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          pin_s1[i] <= '0;
          pin_s2[i] <= '0;
        end else begin
          pin_s1[i] <= (i == 0) ? sensor_pos_a : sensor_pos_b;
          pin_s2[i] <= pin_s1[i];
        end
      end
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          ctrl_q[i] <= '0;
          cmd_q[i] <= '0;
          vlim_q[i] <= TPSQ_VEL_LIM_RESET;
          deca_q[i] <= TPSQ_DECEL_RESET;
          decb_q[i] <= TPSQ_DECEL_RESET;
          stop_q[i] <= TPSQ_STOP_RESET;
          jogv_q[i] <= TPSQ_JOG_VEL_RESET;
          win_q[i] <= TPSQ_WINDOW_RESET;
          acc_q[i] <= TPSQ_ACCEL_RESET;
        end else if (w) begin
          if (axis_ofs == TPSQ_OFS_CTRL) ctrl_q[i] <= wdata[3:0];
          if (axis_ofs == TPSQ_OFS_CMD_POS) cmd_q[i] <= wdata[W-1:0];
          if (axis_ofs == TPSQ_OFS_VEL_LIM) vlim_q[i] <= wdata[W-1:0];
          if (axis_ofs == TPSQ_OFS_DECEL_A) deca_q[i] <= wdata[W-1:0];
          if (axis_ofs == TPSQ_OFS_DECEL_B) decb_q[i] <= wdata[W-1:0];
          if (axis_ofs == TPSQ_OFS_STOP_DIST) stop_q[i] <= wdata[W-1:0];
          if (axis_ofs == TPSQ_OFS_JOG_VEL) jogv_q[i] <= wdata[W-1:0];
          if (axis_ofs == TPSQ_OFS_WINDOW) win_q[i] <= wdata[W-1:0];
          if (axis_ofs == TPSQ_OFS_ACCEL) acc_q[i] <= wdata[W-1:0];
        end
      end
      // each axis has its own settings except the shared curve and nc mode bits, and its own sequencer
      assign ax[i].enable = ctrl_q[i][TPSQ_CTRL_ENABLE];
      assign ax[i].start = ctrl_q[i][TPSQ_CTRL_START];
      assign ax[i].jog_plus = ctrl_q[i][TPSQ_CTRL_JOG_PLUS];
      assign ax[i].jog_minus = ctrl_q[i][TPSQ_CTRL_JOG_MINUS];
      assign ax[i].cmd_pos = cmd_q[i];
      assign ax[i].act_pos = pin_s2[i];
      assign ax[i].vel_lim = vlim_q[i];
      assign ax[i].decel_a = deca_q[i];
      assign ax[i].decel_b = decb_q[i];
      assign ax[i].stop_dist = stop_q[i];
      assign ax[i].jog_vel = jogv_q[i];
      assign ax[i].window = win_q[i];
      assign ax[i].accel = acc_q[i];
      assign ax[i].root_decel_curve = mode_q[TPSQ_MODE_ROOT];
      assign ax[i].nc_mode = mode_q[TPSQ_MODE_NC];
      assign drv[i] = ax[i].drive;
      assign reached[i] = ax[i].target_reached_flag;
      assign inwin[i] = ax[i].in_window;
      tpsq_axis tpsq_axis_inst (
        .clk(clk),
        .arst_n(arst_n),
        .ax(ax[i])
      );
    end
  endgenerate

  // coupling only acts while both axes are enabled
  wire sync_on = mode_q[TPSQ_MODE_SYNC] && ax[0].enable && ax[1].enable;
  wire sync_avg = mode_q[TPSQ_MODE_AVG];
  wire signed [W:0] pos_diff = $signed({pin_s2[0][W-1], pin_s2[0]}) - $signed({pin_s2[1][W-1], pin_s2[1]});
  wire signed [W:0] diff_gain = pos_diff >>> TPSQ_SYNC_SH;
  wire signed [W:0] half_gain = pos_diff >>> (TPSQ_SYNC_SH + 1);
  // slave follows master drive plus a position catch-up term; without spare speed it cannot catch up
  wire signed [W+1:0] slave_sum = $signed({drv[0][W-1], drv[0][W-1], drv[0]}) + $signed({diff_gain[W], diff_gain});
  wire signed [W+1:0] vmax = $signed({3'b000, {(W-1){1'b1}}});
  wire signed [W-1:0] slave_vel = (slave_sum > vmax) ? W'(vmax) : (slave_sum < -vmax) ? W'(-vmax) : W'(slave_sum);
  wire signed [W-1:0] half_sat = (half_gain > W'(vmax)) ? W'(vmax) :
    (half_gain < -W'(vmax)) ? W'(-vmax) : W'(half_gain);
  assign ax[1].sync_ovr = sync_on && !sync_avg;
  assign ax[1].sync_vel = slave_vel;
  // average mode pulls both axes toward their mean position
  assign ax[0].sync_ovr = 1'b0;
  assign ax[0].sync_vel = '0;
  assign ax[0].sync_corr = (sync_on && sync_avg) ? -half_sat : '0;
  assign ax[1].sync_corr = (sync_on && sync_avg) ? half_sat : '0;

  wire [TPSQ_IRQ_W-1:0] ev_now = {inwin, reached};
  wire [TPSQ_IRQ_W-1:0] ev_rise = ev_now & ~ev_prev_q;
  // a new event in the clearing cycle stays set
  wire [TPSQ_IRQ_W-1:0] ists_d = (ists_q & ~(wr_istat ? wdata[TPSQ_IRQ_W-1:0] : '0)) | ev_rise;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= TPSQ_MODE_RESET;
      imask_q <= '0;
      ists_q <= '0;
      ev_prev_q <= '0;
      ready_q <= 1'b0;
    end else begin
      if (wr_mode) mode_q <= wdata[3:0];
      if (wr_imask) imask_q <= wdata[TPSQ_IRQ_W-1:0];
      ists_q <= ists_d;
      ev_prev_q <= ev_now;
      ready_q <= 1'b1;
    end
  end

  wire rsel = addr[6];
  wire axis_rd = !addr[7];
  wire [31:0] stat_word = {28'h0000000, drv[rsel] != '0, inwin[rsel], reached[rsel], ready_q};
  wire [31:0] axis_word =
    axis_ofs == TPSQ_OFS_CTRL ? {28'h0000000, ctrl_q[rsel]} :
    axis_ofs == TPSQ_OFS_CMD_POS ? {16'h0000, cmd_q[rsel]} :
    axis_ofs == TPSQ_OFS_VEL_LIM ? {16'h0000, vlim_q[rsel]} :
    axis_ofs == TPSQ_OFS_DECEL_A ? {16'h0000, deca_q[rsel]} :
    axis_ofs == TPSQ_OFS_DECEL_B ? {16'h0000, decb_q[rsel]} :
    axis_ofs == TPSQ_OFS_STOP_DIST ? {16'h0000, stop_q[rsel]} :
    axis_ofs == TPSQ_OFS_JOG_VEL ? {16'h0000, jogv_q[rsel]} :
    axis_ofs == TPSQ_OFS_WINDOW ? {16'h0000, win_q[rsel]} :
    axis_ofs == TPSQ_OFS_ACCEL ? {16'h0000, acc_q[rsel]} :
    axis_ofs == TPSQ_OFS_ACT_POS ? {16'h0000, pin_s2[rsel]} :
    axis_ofs == TPSQ_OFS_STATUS ? stat_word : 32'h00000000;
  wire [31:0] rd_word =
    axis_rd ? axis_word :
    addr == TPSQ_ADDR_MODE ? {28'h0000000, mode_q} :
    addr == TPSQ_ADDR_IRQ_STAT ? {28'h0000000, ists_q} :
    addr == TPSQ_ADDR_IRQ_MASK ? {28'h0000000, imask_q} : 32'h00000000;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rdata_q <= '0;
    else rdata_q <= rd ? rd_word : 32'h00000000;
  end

  assign rdata = rdata_q;
  assign valve_cmd_a = drv[0];
  assign valve_cmd_b = drv[1];
  assign ready = ready_q;
  assign target_reached_flag = reached;
  assign in_window = inwin;
  assign irq = |(ists_q & imask_q);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_slave_follows: assert property (sync_on && !sync_avg |=> drv[1] == $past(slave_vel))
    else $error("slave axis not driven by sync controller");
  a_avg_symmetric: assert property (sync_on && sync_avg |-> ax[0].sync_corr == -ax[1].sync_corr)
    else $error("average mode correction not symmetric");
  a_irq_sticky: assert property (ev_rise[0] |=> ists_q[0] ##1 (ists_q[0] || $past(wr_istat && wdata[0])))
    else $error("reached event lost from status");
endmodule
`default_nettype wire

// ### tb/tpsq_plant.sv
// behavioural cylinder and sensor: position integrates the valve demand
`default_nettype none
module tpsq_plant #(
  parameter logic signed [15:0] INIT = 16'sh1000
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic freeze,
  input wire logic [15:0] valve_cmd,
  output logic [15:0] sensor_pos
);
  timeunit 1ns;
  timeprecision 1ns;
  logic signed [15:0] pos_q;
  // frozen by default so that profile values can be predicted exactly from a fixed error
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_q <= INIT;
    end else if (!freeze) begin
      pos_q <= pos_q + ($signed(valve_cmd) >>> 4);
    end
  end
  assign sensor_pos = pos_q;
endmodule
`default_nettype wire

// ### tb/two_axis_position_sequencer_test.sv
// self-checking bench for the two-axis position sequencer
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module two_axis_position_sequencer_test import tpsq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic freeze = 1'b1;
  logic [31:0] rdata;
  logic [15:0] pos_a, pos_b, valve_a, valve_b;
  logic ready, irq;
  logic [1:0] reached, win;
  int fail_count = 0;
  int tests_run = 0;
  localparam logic [7:0] A_CTRL = {2'b00, TPSQ_OFS_CTRL};
  localparam logic [7:0] A_CMD = {2'b00, TPSQ_OFS_CMD_POS};
  localparam logic [7:0] A_VEL = {2'b00, TPSQ_OFS_VEL_LIM};
  localparam logic [7:0] A_DECB = {2'b00, TPSQ_OFS_DECEL_B};
  localparam logic [7:0] A_POS = {2'b00, TPSQ_OFS_ACT_POS};
  localparam logic [7:0] A_STAT = {2'b00, TPSQ_OFS_STATUS};
  localparam logic [7:0] B_CTRL = TPSQ_AXIS_STRIDE + A_CTRL;
  always #20 clk = ~clk;
  tpsq_top tpsq_top_inst (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sensor_pos_a(pos_a), .sensor_pos_b(pos_b), .valve_cmd_a(valve_a), .valve_cmd_b(valve_b),
    .ready(ready), .target_reached_flag(reached), .in_window(win), .irq(irq));
  tpsq_plant #(.INIT(16'sh1000)) tpsq_plant_inst (.clk(clk), .arst_n(arst_n), .freeze(freeze),
    .valve_cmd(valve_a), .sensor_pos(pos_a));
  tpsq_plant #(.INIT(16'sh0F00)) tpsq_plant_inst_b (.clk(clk), .arst_n(arst_n), .freeze(freeze),
    .valve_cmd(valve_b), .sensor_pos(pos_b));
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic t_reset();
    logic [31:0] d;
    `CHK(ready, 1'b1)
    rreg(A_VEL, d);
    `CHK(d, 32'h0000_1000)
    rreg(TPSQ_ADDR_MODE, d);
    `CHK(d, 32'h0000_0004)
    rreg(8'h3C, d);
    `CHK(d, 32'h0000_0000)
    wreg(A_CTRL, 32'h0000_0006);
    settle();
    `CHK(valve_a, 16'h0000)
    `CHK(reached, 2'b00)
    $display("reset and disabled test done");
  endtask
  task automatic t_profile();
    logic [31:0] d;
    logic [15:0] v1;
    wreg(A_CTRL, 32'h0000_0001);
    wreg(B_CTRL, 32'h0000_0001);
    settle();
    rreg(A_POS, d);
    `CHK(d, 32'h0000_1000)
    `CHK(reached, 2'b11)
    wreg(TPSQ_ADDR_MODE, 32'h0000_0000);
    wreg(A_CMD, 32'h0000_1200);
    wreg(A_CTRL, 32'h0000_0003);
    settle();
    `CHK(reached[0], 1'b0)
    `CHK(valve_a, 16'h0800)
    `CHK(valve_b, 16'h0000)
    wreg(TPSQ_ADDR_MODE, 32'h0000_0004);
    settle();
    `CHK(valve_a, 16'h0C00)
    wreg(A_CTRL, 32'h0000_0001);
    settle();
    `CHK(valve_a, 16'h0700)
    wreg(A_DECB, 32'h0000_0800);
    wreg(TPSQ_ADDR_MODE, 32'h0000_0000);
    wreg(A_CMD, 32'h0000_0E00);
    wreg(A_CTRL, 32'h0000_0003);
    settle();
    `CHK(valve_a, 16'hFC00)
    wreg(A_CTRL, 32'h0000_0001);
    wreg(A_VEL, 32'h0000_0300);
    wreg(A_CMD, 32'h0000_0000);
    wreg(A_CTRL, 32'h0000_0003);
    settle();
    `CHK(valve_a, 16'hFD00)
    // park at the sensor position so the velocity ramp starts from rest
    wreg(A_CMD, 32'h0000_1000);
    wreg(A_CTRL, 32'h0000_0001);
    wreg(A_CTRL, 32'h0000_0003);
    settle();
    wreg(TPSQ_ADDR_MODE, 32'h0000_000C);
    wreg(A_CMD, 32'h0000_0000);
    wreg(A_CTRL, 32'h0000_0001);
    wreg(A_CTRL, 32'h0000_0003);
    repeat (3) @(posedge clk);
    @(negedge clk);
    v1 = valve_a;
    @(negedge clk);
    `CHK(16'(v1 - valve_a), 16'h0010)
    repeat (80) @(negedge clk);
    `CHK(valve_a, 16'hFD00)
    wreg(A_CTRL, 32'h0000_0001);
    wreg(TPSQ_ADDR_MODE, 32'h0000_0004);
    wreg(A_VEL, 32'h0000_1000);
    $display("profile test done");
  endtask
  task automatic t_reach();
    logic [31:0] d;
    wreg(A_CMD, 32'h0000_1001);
    wreg(TPSQ_ADDR_IRQ_STAT, 32'h0000_000F);
    wreg(TPSQ_ADDR_IRQ_MASK, 32'h0000_0001);
    wreg(A_CTRL, 32'h0000_0003);
    settle();
    `CHK(reached[0], 1'b1)
    `CHK(win[0], 1'b1)
    `CHK(irq, 1'b1)
    rreg(TPSQ_ADDR_IRQ_STAT, d);
    `CHK(d, 32'h0000_0005)
    rreg(A_STAT, d);
    `CHK(d, 32'h0000_0007)
    wreg(TPSQ_ADDR_IRQ_MASK, 32'h0000_0000);
    @(negedge clk);
    `CHK(irq, 1'b0)
    wreg(TPSQ_ADDR_IRQ_MASK, 32'h0000_0001);
    wreg(TPSQ_ADDR_IRQ_STAT, 32'h0000_0001);
    @(negedge clk);
    `CHK(irq, 1'b0)
    wreg(A_CTRL, 32'h0000_0001);
    settle();
    `CHK(win[0], 1'b0)
    $display("reach and interrupt test done");
  endtask
  task automatic t_jog();
    logic [31:0] d;
    wreg(A_CTRL, 32'h0000_0005);
    settle();
    `CHK(valve_a, 16'h0200)
    rreg(A_STAT, d);
    `CHK(d, 32'h0000_0009)
    freeze <= 1'b0;
    repeat (20) @(posedge clk);
    freeze <= 1'b1;
    wreg(A_CTRL, 32'h0000_0009);
    settle();
    `CHK(valve_a, 16'hFE00)
    wreg(A_CTRL, 32'h0000_000D);
    settle();
    `CHK(valve_a, 16'h0000)
    wreg(A_CTRL, 32'h0000_0001);
    settle();
    `CHK(valve_a, 16'h0000)
    `CHK(reached[0], 1'b1)
    rreg(A_POS, d);
    `CHK(d[15:0] > 16'h1000, 1'b1)
    $display("jog test done");
  endtask
  task automatic t_sync();
    logic [31:0] d;
    logic signed [15:0] df;
    rreg(A_POS, d);
    df = $signed(d[15:0]) - 16'sh0F00;
    // master velocity limit set to three quarters of its 0x1000 reset value
    wreg(A_VEL, 32'h0000_0C00);
    wreg(TPSQ_ADDR_MODE, 32'h0000_0005);
    settle();
    `CHK(valve_b, 16'(df >>> 2))
    wreg(TPSQ_ADDR_MODE, 32'h0000_0007);
    settle();
    `CHK(valve_b, 16'(df >>> 3))
    `CHK(valve_a, 16'(-(df >>> 3)))
    $display("sync test done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    t_reset();
    t_profile();
    t_reach();
    t_jog();
    t_sync();
    conclude();
  end
  initial begin
    #(40 * 20000);
    fail_count++;
    $display("watchdog expired");
    conclude();
  end
endmodule
`default_nettype wire
